// ---- core/serial_cfg_pkg.sv ----
// Purpose: shared constants for the serial port configuration and address filter
// Assumes: 20 MHz system clock, eight-bit command characters
// Notes:   baud codes index the common rate table used by both ports
package serial_cfg_pkg;

  // ====================
  // clock and baud rates
  // ====================
  localparam int unsigned CLK_HZ = 20000000;  // system clock rate
  localparam int unsigned BAUD_COUNT = 8;     // selectable rates per port

  typedef enum logic [2:0] {
    BAUD_1200,
    BAUD_2400,
    BAUD_4800,
    BAUD_9600,
    BAUD_19200,
    BAUD_38400,
    BAUD_57600,
    BAUD_115200
  } baud_sel_t;

  // rate table in bits per second, indexed by baud_sel_t
  localparam int unsigned BAUD_RATE [BAUD_COUNT] = '{
    1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200
  };

  // clocks per bit, rounded down so the tick is never late
  function automatic logic [15:0] bit_div(input baud_sel_t sel);
    bit_div = 16'(CLK_HZ / BAUD_RATE[sel]);
  endfunction : bit_div

  // ====================
  // factory defaults
  // ====================
  localparam baud_sel_t MAIN_BAUD_RST = BAUD_9600;  // main port default
  localparam baud_sel_t MB_BAUD_RST   = BAUD_9600;  // fieldbus port default
  localparam logic [7:0] STATION_RST  = 8'h11;      // station address default
  localparam logic [7:0] STATION_MIN  = 8'h01;      // lowest own address
  localparam logic [7:0] BCAST_ADDR   = 8'h00;      // global address
  localparam logic [7:0] MB_ID_RST    = 8'h0B;      // device id default, decimal 11
  localparam logic [7:0] MB_ID_MIN    = 8'h01;      // lowest device id
  localparam logic [7:0] MB_ID_MAX    = 8'hF7;      // highest device id, 247

  typedef enum logic [1:0] {
    PAR_NONE,
    PAR_ODD,
    PAR_EVEN
  } parity_t;

  localparam parity_t MB_PAR_RST = PAR_NONE;  // parity default
  localparam logic MB_TWO_STOP_RST = 1'b1;    // two stop bits default

  // ====================
  // filter buffer
  // ====================
  localparam int unsigned BUF_DEPTH = 2;  // entries in the output buffer

endpackage : serial_cfg_pkg

// ---- core/cmd_buf2.sv ----
// Purpose: two-entry valid/ready buffer for accepted command characters
// Assumes: single clock, source and sink on the same domain
// Notes:   ready drops only when both entries hold data
`timescale 1ns/1ns
module cmd_buf2
  import serial_cfg_pkg::*;
#(
  parameter int unsigned WIDTH = 9
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);

  // ====================
  // storage
  // ====================
  logic [WIDTH-1:0] mem [BUF_DEPTH];  // entry array
  logic             wr_ptr;           // next slot to fill
  logic             rd_ptr;           // next slot to drain
  logic [1:0]       count;            // entries held
  logic             push;             // write this cycle
  logic             pop;              // read this cycle

  assign push        = in_valid_i && (count != 2'h2);
  assign pop         = out_valid_o && out_ready_i;
  assign in_ready_o  = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign out_data_o  = mem[rd_ptr];

  // entry write, data needs no reset
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and occupancy
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule : cmd_buf2

// ---- core/serial_port_config_addr_filter.sv ----
// Purpose: holds both serial ports' settings and filters command frames by address
// Assumes: an upstream receiver delivers the address character then payload characters
// Notes:   settings are written by strobes; out-of-range writes are refused and flagged
`timescale 1ns/1ns

// Function
// - main port eight rates, 9600 default
// - fieldbus port same rates, independent, 9600
// - station address eight bits, default 11h
// - station address 01h..FFh only, refuse 00h
// - address 00h executes, reply suppressed; the point-to-point variant still answers it
// - point-to-point variant does no address filtering
// - device id 1 to 247, default 11
// - fieldbus port uses only RTU framing
// - parity none, odd or even; none default
// - one or two stop bits; two default
// - fieldbus settings must match the master
// - main port rate must match the host
module serial_port_config_addr_filter
  import serial_cfg_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // configuration writes
  input  wire logic              multidrop_i,       // high on the RS485 variant
  input  wire logic              main_baud_we_i,    // main rate write strobe
  input  wire logic [2:0]        main_baud_i,       // main rate code
  input  wire logic              station_we_i,      // station address write strobe
  input  wire logic [7:0]        station_i,         // new station address
  input  wire logic              mb_baud_we_i,      // fieldbus rate write strobe
  input  wire logic [2:0]        mb_baud_i,         // fieldbus rate code
  input  wire logic              mb_id_we_i,        // device id write strobe
  input  wire logic [7:0]        mb_id_i,           // new device id
  input  wire logic              mb_frame_we_i,     // parity and stop write strobe
  input  wire logic [1:0]        mb_parity_i,       // parity code
  input  wire logic              mb_two_stop_i,     // high for two stop bits
  // received command characters
  input  wire logic              rx_valid_i,        // character present
  input  wire logic [DATA_W-1:0] rx_data_i,         // character value
  input  wire logic              rx_first_i,        // character is the address
  input  wire logic              rx_last_i,         // character ends the command
  output logic                   rx_ready_o,        // filter can take a character
  // accepted command stream
  output logic                   cmd_valid_o,       // accepted character present
  output logic [DATA_W-1:0]      cmd_data_o,        // accepted character
  output logic                   cmd_last_o,        // ends the command
  input  wire logic              cmd_ready_i,       // executor takes it
  output logic                   reply_en_o,        // current command may be answered
  output logic                   drop_o,            // pulse: foreign command dropped
  // settings readback
  output logic [2:0]             main_baud_o,       // main rate code
  output logic [15:0]            main_div_o,        // main clocks per bit
  output logic [7:0]             station_o,         // station address
  output logic [2:0]             mb_baud_o,         // fieldbus rate code
  output logic [15:0]            mb_div_o,          // fieldbus clocks per bit
  output logic [7:0]             mb_id_o,           // device id
  output logic [1:0]             mb_parity_o,       // parity code
  output logic                   mb_two_stop_o,     // two stop bits
  output logic                   mb_rtu_o,          // framing is RTU
  output logic                   cfg_err_o          // pulse: refused setting
);

  // ====================
  // input sampling
  // ====================
  // the variant strap comes from a pin, so it takes three flops
  logic [2:0] md_sync;   // strap synchroniser chain
  logic       md_level;  // agreed strap level

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      md_sync <= 3'h0;
    end else begin
      md_sync <= {md_sync[1:0], multidrop_i};
    end
  end

  // a change counts only once the last two stages agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      md_level <= 1'b0;
    end else if (md_sync[2] == md_sync[1]) begin
      md_level <= md_sync[2];
    end
  end

  // ====================
  // main port settings
  // ====================
  baud_sel_t main_baud;  // main rate
  logic [7:0] station;   // own station address

  // every 3-bit code is a legal rate, so no refusal here
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_baud <= MAIN_BAUD_RST;
    end else if (main_baud_we_i) begin
      main_baud <= baud_sel_t'(main_baud_i);
    end
  end

  // the global address can never become our own
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      station <= STATION_RST;
    end else if (station_we_i && (station_i >= STATION_MIN)) begin
      station <= station_i;
    end
  end

  // ====================
  // fieldbus port settings
  // ====================
  baud_sel_t  mb_baud;      // fieldbus rate
  logic [7:0] mb_id;        // device id
  parity_t    mb_parity;    // parity mode
  logic       mb_two_stop;  // stop bit count

  // independent of the main port rate
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mb_baud <= MB_BAUD_RST;
    end else if (mb_baud_we_i) begin
      mb_baud <= baud_sel_t'(mb_baud_i);
    end
  end

  // ids outside 1..247 are kept out of the register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mb_id <= MB_ID_RST;
    end else if (mb_id_we_i && (mb_id_i >= MB_ID_MIN) && (mb_id_i <= MB_ID_MAX)) begin
      mb_id <= mb_id_i;
    end
  end

  // parity code 3 is illegal and leaves both fields unchanged
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mb_parity   <= MB_PAR_RST;
      mb_two_stop <= MB_TWO_STOP_RST;
    end else if (mb_frame_we_i && (mb_parity_i != 2'h3)) begin
      mb_parity   <= parity_t'(mb_parity_i);
      mb_two_stop <= mb_two_stop_i;
    end
  end

  // refused writes flag a single-cycle error
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_err_o <= 1'b0;
    end else begin
      cfg_err_o <= (station_we_i && (station_i < STATION_MIN))
                 || (mb_id_we_i && ((mb_id_i < MB_ID_MIN) || (mb_id_i > MB_ID_MAX)))
                 || (mb_frame_we_i && (mb_parity_i == 2'h3));
    end
  end

  // ====================
  // settings readback
  // ====================
  // dividers registered so outputs come straight from flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_baud_o   <= 3'h0;
      main_div_o    <= 16'h0000;
      station_o     <= 8'h00;
      mb_baud_o     <= 3'h0;
      mb_div_o      <= 16'h0000;
      mb_id_o       <= 8'h00;
      mb_parity_o   <= 2'h0;
      mb_two_stop_o <= 1'b0;
      mb_rtu_o      <= 1'b0;
    end else begin
      main_baud_o   <= main_baud;
      main_div_o    <= bit_div(main_baud);
      station_o     <= station;
      mb_baud_o     <= mb_baud;
      mb_div_o      <= bit_div(mb_baud);
      mb_id_o       <= mb_id;
      mb_parity_o   <= mb_parity;
      mb_two_stop_o <= mb_two_stop;
      mb_rtu_o      <= 1'b1;
    end
  end

  // ====================
  // address filter
  // ====================
  typedef enum logic [1:0] {
    F_ADDR,   // waiting for an address character
    F_PASS,   // forwarding an accepted command
    F_SKIP    // swallowing a foreign command
  } filt_state_t;

  filt_state_t state;        // filter state
  logic        buf_ready;    // buffer can take a character
  logic        take;         // character consumed this cycle
  logic        addr_bcast;   // address is the global one
  logic        addr_match;   // command is for this station
  logic        fwd;          // push character into buffer

  assign addr_bcast = (rx_data_i[7:0] == BCAST_ADDR);
  // the point-to-point variant accepts every address
  assign addr_match = !md_level || addr_bcast || (rx_data_i[7:0] == station);
  // skipping never stalls, passing waits for buffer room
  assign take = rx_valid_i && ((state == F_SKIP) || buf_ready);
  assign rx_ready_o = (state == F_SKIP) || buf_ready;
  assign fwd = rx_valid_i && buf_ready && (state != F_SKIP)
             && !((state == F_ADDR) && !addr_match);

  // frame walk, address character decides the whole command
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= F_ADDR;
    end else if (take) begin
      unique case (state)
        F_ADDR: begin
          if (rx_last_i) begin
            state <= F_ADDR;
          end else if (addr_match) begin
            state <= F_PASS;
          end else begin
            state <= F_SKIP;
          end
        end
        F_PASS, F_SKIP: begin
          // an unexpected first mark is ignored; only a last mark returns to F_ADDR
          if (rx_last_i) begin
            state <= F_ADDR;
          end
        end
      endcase
    end
  end

  // reply permission latched per command
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reply_en_o <= 1'b0;
    end else if (take && (state == F_ADDR)) begin
      // on the multidrop variant global commands run everywhere but nobody answers
      reply_en_o <= addr_match && !(md_level && addr_bcast);
    end
  end

  // dropped command reported once, at its address
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drop_o <= 1'b0;
    end else begin
      drop_o <= take && (state == F_ADDR) && !addr_match;
    end
  end

  // ====================
  // output buffer
  // ====================
  // two entries absorb one stall without losing a character
  logic [DATA_W:0] buf_out;    // last flag and data
  logic            buf_valid;  // buffer not empty
  logic            out_pop;    // output register load
  logic            out_free;   // output register empty or draining

  assign out_free = !cmd_valid_o || cmd_ready_i;
  assign out_pop  = buf_valid && out_free;

  cmd_buf2 #(
    .WIDTH (DATA_W + 1)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   ({rx_last_i, rx_data_i}),
    .in_valid_i  (fwd),
    .in_ready_o  (buf_ready),
    .out_data_o  (buf_out),
    .out_valid_o (buf_valid),
    .out_ready_i (out_free)
  );

  // output stage registered, executor stalls through cmd_ready_i
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_data_o  <= '0;
      cmd_last_o  <= 1'b0;
    end else if (out_free) begin
      cmd_valid_o <= buf_valid;
      if (out_pop) begin
        cmd_data_o <= buf_out[DATA_W-1:0];
        cmd_last_o <= buf_out[DATA_W];
      end
    end
  end

endmodule : serial_port_config_addr_filter

// ---- sim/serial_port_config_addr_filter_checker.sv ----
// Purpose: concurrent checks on the config and address filter ports
// Assumes: single clock domain, async active-low reset
// Notes:   address state is tracked here from the character handshake
`timescale 1ns/1ns
module serial_port_config_addr_filter_checker
  import serial_cfg_pkg::*;
#(
  parameter int unsigned DATA_W = 8
) (
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              multidrop_i,
  input wire logic              main_baud_we_i,
  input wire logic [2:0]        main_baud_i,
  input wire logic              station_we_i,
  input wire logic [7:0]        station_i,
  input wire logic              mb_id_we_i,
  input wire logic [7:0]        mb_id_i,
  input wire logic              mb_frame_we_i,
  input wire logic [1:0]        mb_parity_i,
  input wire logic              rx_valid_i,
  input wire logic [DATA_W-1:0] rx_data_i,
  input wire logic              rx_last_i,
  input wire logic              rx_ready_o,
  input wire logic              cmd_valid_o,
  input wire logic [DATA_W-1:0] cmd_data_o,
  input wire logic              cmd_last_o,
  input wire logic              cmd_ready_i,
  input wire logic              reply_en_o,
  input wire logic              drop_o,
  input wire logic [2:0]        main_baud_o,
  input wire logic [15:0]       main_div_o,
  input wire logic [7:0]        station_o,
  input wire logic [7:0]        mb_id_o,
  input wire logic              mb_rtu_o,
  input wire logic              cfg_err_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // ====================
  // helper state
  // ====================
  logic take;     // character handshake
  logic at_addr;  // next character is an address
  assign take = rx_valid_i && rx_ready_o;

  // address expected after reset and after each last character
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      at_addr <= 1'b1;
    end else if (take) begin
      at_addr <= rx_last_i;
    end
  end

  // ====================
  // configuration
  // ====================
  property p_station_upd;
    station_we_i && station_i != BCAST_ADDR |-> ##2 station_o == $past(station_i, 2);
  endproperty
  a_station_upd: assert property (p_station_upd)
    else $error("station readback wrong");

  property p_station_zero;
    station_we_i && station_i == BCAST_ADDR |=> cfg_err_o;
  endproperty
  a_station_zero: assert property (p_station_zero)
    else $error("global station address not refused");

  property p_id_bad;
    mb_id_we_i && (mb_id_i < MB_ID_MIN || mb_id_i > MB_ID_MAX) |=> cfg_err_o;
  endproperty
  a_id_bad: assert property (p_id_bad)
    else $error("out of range device id not refused");

  property p_id_upd;
    mb_id_we_i && mb_id_i inside {[MB_ID_MIN:MB_ID_MAX]} |-> ##2 mb_id_o == $past(mb_id_i, 2);
  endproperty
  a_id_upd: assert property (p_id_upd)
    else $error("device id readback wrong");

  property p_main_baud;
    main_baud_we_i |-> ##2 main_baud_o == $past(main_baud_i, 2);
  endproperty
  a_main_baud: assert property (p_main_baud)
    else $error("main rate readback wrong");

  // code and divider load on the same edge, so they agree from the first load after reset (reset gives code 0, divider 0)
  property p_main_div;
    $past(rst_n_i) |-> main_div_o == 16'(CLK_HZ / BAUD_RATE[main_baud_o]);
  endproperty
  a_main_div: assert property (p_main_div)
    else $error("main divider does not match rate");

  property p_parity_bad;
    mb_frame_we_i && mb_parity_i == 2'h3 |=> cfg_err_o;
  endproperty
  a_parity_bad: assert property (p_parity_bad)
    else $error("parity code 3 not refused");

  property p_rtu;
    $past(rst_n_i) |-> mb_rtu_o;
  endproperty
  a_rtu: assert property (p_rtu)
    else $error("framing not RTU");

  // ====================
  // command stream
  // ====================
  property p_cmd_hold;
    cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_data_o) && $stable(cmd_last_o);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold)
    else $error("stalled output changed");

  // strap must have been steady long enough to pass its synchroniser
  sequence s_md_addr;
    multidrop_i [*6] ##0 (take && at_addr);
  endsequence

  sequence s_p2p_addr;
    (!multidrop_i) [*6] ##0 (take && at_addr);
  endsequence

  property p_p2p;
    s_p2p_addr |=> reply_en_o && !drop_o;
  endproperty
  a_p2p: assert property (p_p2p)
    else $error("address filtered on point to point");

  property p_bcast;
    s_md_addr ##0 (rx_data_i == BCAST_ADDR) |=> !reply_en_o && !drop_o;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("global command answered or dropped");

  property p_match;
    s_md_addr ##0 (rx_data_i == station_o) |=> reply_en_o && !drop_o;
  endproperty
  a_match: assert property (p_match)
    else $error("own address not accepted");

  property p_foreign;
    s_md_addr ##0 (rx_data_i != BCAST_ADDR && rx_data_i != station_o) |=> drop_o;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("foreign command not dropped");
endmodule : serial_port_config_addr_filter_checker

// ---- sim/cmd_host_model.sv ----
// Purpose: host side that sends command characters into the filter
// Assumes: one clock shared with the filter
// Notes:   released data shows the inverse of the last character
`timescale 1ns/1ns
module cmd_host_model (
  input  wire logic       clk_i,
  input  wire logic       rx_ready_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_first_o,
  output logic            rx_last_o
);
  int stuck;  // handshakes that never completed

  initial begin
    stuck = 0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'hA5;
    rx_first_o = 1'b0;
    rx_last_o = 1'b0;
  end

  // ====================
  // frame sender
  // ====================
  // first character of each frame is the address; any station may be addressed
  // gap 0 keeps valid up between characters, else released for gap edges
  task automatic send_frame(input logic [7:0] b[$], input int gap);
    int n;
    @(posedge clk_i);
    foreach (b[i]) begin
      rx_valid_o <= 1'b1;
      rx_data_o <= b[i];
      rx_first_o <= (i == 0);
      rx_last_o <= (i == b.size() - 1);
      n = 0;
      // hold until ready is seen high at an edge
      do begin
        @(posedge clk_i);
        n++;
      end while (!rx_ready_i && n < 100);
      if (n >= 100) stuck++;
      if (gap > 0 || i == b.size() - 1) begin
        rx_valid_o <= 1'b0;
        rx_data_o <= ~b[i];
        repeat (gap) @(posedge clk_i);
      end
    end
  endtask : send_frame
endmodule : cmd_host_model

// ---- sim/serial_port_config_addr_filter_bench.sv ----
// Purpose: self-checking bench for the config and address filter
// Assumes: 20 MHz clock, reset held four cycles
// Notes:   settings are written by strobe tasks, frames by the host model
`timescale 1ns/1ns
module serial_port_config_addr_filter_bench;
  import serial_cfg_pkg::*;
  logic clk_i = 1'b0, rst_n_i = 1'b0, multidrop_i = 1'b0, cmd_ready_i = 1'b1;
  logic main_baud_we_i = 1'b0, station_we_i = 1'b0, mb_baud_we_i = 1'b0;
  logic mb_id_we_i = 1'b0, mb_frame_we_i = 1'b0, mb_two_stop_i = 1'b0;
  logic [2:0] main_baud_i = 3'h0, mb_baud_i = 3'h0;
  logic [7:0] station_i = 8'h00, mb_id_i = 8'h00;
  logic [1:0] mb_parity_i = 2'h0;
  logic rx_valid_i, rx_first_i, rx_last_i, rx_ready_o, cmd_valid_o, cmd_last_o;
  logic [7:0] rx_data_i, cmd_data_o, station_o, mb_id_o;
  logic reply_en_o, drop_o, mb_two_stop_o, mb_rtu_o, cfg_err_o;
  logic [2:0] main_baud_o, mb_baud_o;
  logic [15:0] main_div_o, mb_div_o;
  logic [1:0] mb_parity_o;
  logic [8:0] got[$];  // accepted characters with last flag
  int failures = 0, n_checks = 0, drops = 0;

  always #25 clk_i = ~clk_i;

  serial_port_config_addr_filter dut_u (.*);
  cmd_host_model host_u (.clk_i, .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .rx_first_o(rx_first_i), .rx_last_o(rx_last_i));

  // sink side: record accepted characters and drop pulses
  always @(posedge clk_i) begin
    if (rst_n_i && cmd_valid_o && cmd_ready_i) got.push_back({cmd_last_o, cmd_data_o});
    if (rst_n_i && drop_o) drops++;
  end

  // ====================
  // tasks
  // ====================
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // one strobe write; sel 0 main rate, 1 station, 2 fieldbus rate, 3 id, 4 framing
  task automatic cfg(input int sel, input logic [7:0] v, input logic bad);
    @(posedge clk_i);
    case (sel)
      0: begin main_baud_we_i <= 1'b1; main_baud_i <= v[2:0]; end
      1: begin station_we_i <= 1'b1; station_i <= v; end
      2: begin mb_baud_we_i <= 1'b1; mb_baud_i <= v[2:0]; end
      3: begin mb_id_we_i <= 1'b1; mb_id_i <= v; end
      default: begin mb_frame_we_i <= 1'b1; mb_parity_i <= v[1:0]; mb_two_stop_i <= v[2]; end
    endcase
    @(posedge clk_i);
    {main_baud_we_i, station_we_i, mb_baud_we_i, mb_id_we_i, mb_frame_we_i} <= '0;
    #1;
    check("cfg_err", 16'(cfg_err_o), 16'(bad));
    repeat (2) @(posedge clk_i);
    #1;
  endtask : cfg

  // send a frame, then compare what came out against what should pass
  task automatic frame(input logic [7:0] b[$], input int gap, input logic fwd, input logic rep);
    int k, base, dbase;
    base = got.size();
    dbase = drops;
    k = 0;
    host_u.send_frame(b, gap);
    while (fwd && got.size() < base + b.size() && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 100) begin
      failures++;
      conclude();
    end
    repeat (3) @(posedge clk_i);
    #1;
    check("count", 16'(got.size() - base), fwd ? 16'(b.size()) : 16'h0000);
    if (fwd) foreach (b[i]) check("char", 16'(got[base+i]), 16'({i == b.size() - 1, b[i]}));
    check("drops", 16'(drops - dbase), 16'(!fwd));
    check("reply_en", 16'(reply_en_o), 16'(rep));
  endtask : frame

  // ====================
  // main sequence
  // ====================
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check("main_baud", 16'(main_baud_o), 16'(MAIN_BAUD_RST));
    check("mb_baud", 16'(mb_baud_o), 16'h0003);
    check("main_div", main_div_o, 16'(CLK_HZ / 9600));
    check("mb_div", mb_div_o, 16'(CLK_HZ / 9600));
    check("station", 16'(station_o), 16'h0011);
    check("mb_id", 16'(mb_id_o), 16'h000B);
    check("parity", 16'(mb_parity_o), 16'h0000);
    check("two_stop", 16'(mb_two_stop_o), 16'h0001);
    check("rtu", 16'(mb_rtu_o), 16'h0001);
    // every rate on each port, the two ports set apart
    for (int k = 0; k < 8; k++) begin
      cfg(0, 8'(k), 1'b0);
      cfg(2, 8'(7 - k), 1'b0);
      check("main_baud", 16'(main_baud_o), 16'(k));
      check("mb_baud", 16'(mb_baud_o), 16'(7 - k));
      check("main_div", main_div_o, 16'(CLK_HZ / BAUD_RATE[k]));
      check("mb_div", mb_div_o, 16'(CLK_HZ / BAUD_RATE[7-k]));
    end
    // station boundaries; global value must leave the old one
    cfg(1, 8'h00, 1'b1);
    check("station", 16'(station_o), 16'h0011);
    cfg(1, 8'hFF, 1'b0);
    check("station", 16'(station_o), 16'h00FF);
    cfg(1, 8'h01, 1'b0);
    check("station", 16'(station_o), 16'h0001);
    // device id boundaries
    cfg(3, 8'h00, 1'b1);
    check("mb_id", 16'(mb_id_o), 16'h000B);
    cfg(3, 8'hF8, 1'b1);
    check("mb_id", 16'(mb_id_o), 16'h000B);
    cfg(3, 8'hF7, 1'b0);
    check("mb_id", 16'(mb_id_o), 16'h00F7);
    cfg(3, 8'h01, 1'b0);
    check("mb_id", 16'(mb_id_o), 16'h0001);
    // all parity codes, stop bits follow the low bit; code 3 refused
    for (int p = 0; p < 4; p++) begin
      cfg(4, 8'({p[0], p[1:0]}), p == 3);
      check("parity", 16'(mb_parity_o), 16'(p < 3 ? p : 2));
      check("two_stop", 16'(mb_two_stop_o), 16'(p < 3 ? p % 2 : 0));
    end
    cfg(1, 8'h22, 1'b0);
    // point to point: any address passes and may be answered; multidrop: own and global pass, foreign dropped
    frame('{8'h55, 8'h01, 8'h02}, 0, 1'b1, 1'b1);
    @(posedge clk_i);
    multidrop_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    frame('{8'h22, 8'hA1, 8'hA2}, 0, 1'b1, 1'b1);
    frame('{8'h00, 8'hB1}, 1, 1'b1, 1'b0);
    frame('{8'h33, 8'hC1, 8'hC2}, 0, 1'b0, 1'b0);
    frame('{8'h22}, 0, 1'b1, 1'b1);
    // sink stalls from before the frame starts: input must refuse, nothing lost
    @(posedge clk_i);
    cmd_ready_i <= 1'b0;
    fork
      frame('{8'h22, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5}, 0, 1'b1, 1'b1);
      begin
        repeat (14) @(posedge clk_i);
        #1;
        check("rx_ready", 16'(rx_ready_o), 16'h0000);
        @(posedge clk_i);
        cmd_ready_i <= 1'b1;
      end
    join
    check("host_stuck", 16'(host_u.stuck), 16'h0000);
    conclude();
  end
endmodule : serial_port_config_addr_filter_bench

bind serial_port_config_addr_filter serial_port_config_addr_filter_checker #(
  .DATA_W(DATA_W)
) chk_u (.*);
